// ### src/serial_timer_debug_pin_mux.sv
// pin function multiplexer for port b pins 1-2, the debug clock pin and port c pins 2-4
// assumes config, peripheral and debug-core signals share clk; pin levels are async
`timescale 1ns/1ps

module serial_timer_debug_pin_mux (
    input  wire logic                                   clk,
    input  wire logic                                   rst_b,
    // configuration
    input  wire pin_mux_pkg::serialMode_t               serial1ModeSelect,
    input  wire logic                                   serial1SpiMaster,
    input  wire logic                                   timer2Ch1OutEn,
    input  wire logic                                   timer2Ch2OutEn,
    input  wire logic [pin_mux_pkg::REMAP_W-1:0]        timer2Remap,
    input  wire logic [pin_mux_pkg::CFG_W-1:0]          portBLowConfig,
    input  wire logic [pin_mux_pkg::CFG_W-1:0]          portCLowConfig,
    input  wire logic [pin_mux_pkg::CFG_W-1:0]          portCHighConfig,
    input  wire logic [pin_mux_pkg::DBG_CFG_W-1:0]      debugPinConfig,
    // peripheral outputs toward the pins
    input  wire logic                                   spiSlaveOut,
    input  wire logic                                   spiMasterOut,
    input  wire logic                                   twiDataOut,
    input  wire logic                                   twiClockOut,
    input  wire logic                                   uartTx,
    input  wire logic                                   timer2Ch1Out,
    input  wire logic                                   timer2Ch2Out,
    input  wire logic [pin_mux_pkg::NUM_PINS-1:0]       gpioOut,
    input  wire logic [pin_mux_pkg::NUM_PINS-1:0]       gpioDriveEn,
    // debug core
    input  wire logic                                   dbgSelectSw,
    input  wire logic                                   dbgSelectJtag,
    input  wire logic                                   jtagTdo,
    input  wire logic                                   swClockOut,
    input  wire logic                                   swClockDriveEn,
    input  wire logic                                   swdioOut,
    input  wire logic                                   swdioDriveEn,
    input  wire logic                                   asyncTraceEn,
    input  wire logic                                   asyncTraceOut,
    input  wire logic                                   syncTraceEn,
    input  wire logic                                   syncTraceClock,
    // pins (inputs async, outputs registered)
    input  wire logic [pin_mux_pkg::NUM_PINS-1:0]       muxPinIn,
    input  wire logic                                   dbgClkPinIn,
    input  wire logic                                   externalReset_n,
    input  wire logic                                   timer2Ch1OtherPinIn,
    input  wire logic                                   timer2Ch2OtherPinIn,
    output logic      [pin_mux_pkg::NUM_PINS-1:0]       muxPinOut,
    output logic      [pin_mux_pkg::NUM_PINS-1:0]       muxPinDrive_b,
    output logic      [pin_mux_pkg::NUM_PINS-1:0]       muxPinPullUp,
    output logic                                        dbgClkPinOut,
    output logic                                        dbgClkPinDrive_b,
    output logic                                        dbgClkPinPullDown,
    // toward peripherals and debug core
    output logic      [pin_mux_pkg::NUM_PINS-1:0]       gpioIn,
    output logic                                        spiMasterIn,
    output logic                                        spiSlaveIn,
    output logic                                        uartRx,
    output logic                                        twiDataIn,
    output logic                                        twiClockIn,
    output logic                                        timer2Ch1CaptureIn,
    output logic                                        timer2Ch2CaptureIn,
    output logic                                        jtagClockIn,
    output logic                                        swClockIn,
    output logic                                        jtagTdiIn,
    output logic                                        jtagTmsIn,
    output logic                                        swdioIn,
    output logic                                        serialWireMode
);

    import pin_mux_pkg::*;

    muxState_t        s;
    muxState_t        n;
    logic [SYNC_W-1:0] sy;
    logic             b1Alt;
    logic             b1Od;
    logic             b2Alt;
    logic             b2Od;
    logic             b1SerialOwn;
    logic             b2SerialOwn;
    logic             remap1;
    logic             remap2;
    logic             dbgDisable;
    logic             swd;
    logic             c2Gpio;
    logic             c2Trace;
    logic             c3Gpio;
    logic             c3Trace;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({timer2Ch2OtherPinIn, timer2Ch1OtherPinIn, externalReset_n,
                   dbgClkPinIn, muxPinIn}),
        .syncOut (sy)
    );

    // ------------------------------------------------------------
    // decode of configuration
    // ------------------------------------------------------------
    assign b1Alt       = fieldIs(portBLowConfig, PB1_FIELD_LSB, CFG_ALT_OUT);
    assign b1Od        = fieldIs(portBLowConfig, PB1_FIELD_LSB, CFG_ALT_OD);
    assign b2Alt       = fieldIs(portBLowConfig, PB2_FIELD_LSB, CFG_ALT_OUT);
    assign b2Od        = fieldIs(portBLowConfig, PB2_FIELD_LSB, CFG_ALT_OD);
    assign remap1      = timer2Remap[REMAP_CH1_BIT];
    assign remap2      = timer2Remap[REMAP_CH2_BIT];
    assign b1SerialOwn = !timer2Ch1OutEn || !remap1;
    assign b2SerialOwn = !timer2Ch2OutEn || !remap2;
    assign dbgDisable  = debugPinConfig[DBG_DISABLE_BIT];
    assign swd         = (s.mode == DBG_SWD);
    assign c2Gpio      = dbgDisable && !portCHighConfig[PC2_HIGH_CFG_BIT];
    assign c2Trace     = swd && asyncTraceEn
                         && fieldIs(portCLowConfig, PC2_FIELD_LSB, CFG_ALT_OUT);
    assign c3Gpio      = dbgDisable || swd;
    assign c3Trace     = syncTraceEn
                         && fieldIs(portCLowConfig, PC3_FIELD_LSB, CFG_ALT_OUT);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        // unclaimed pins fall back to gpio
        n.pinOut     = gpioOut;
        n.pinDrive_b = ~gpioDriveEn;
        n.pinPullUp  = ZERO_PINS;
        n.gpioIn     = sy[NUM_PINS-1:0];

        // external reset wins over any switch request from the debugger
        if (!sy[SY_EXT_RST]) begin
            n.mode = DBG_JTAG;
        end else if (dbgSelectSw) begin
            n.mode = DBG_SWD;
        end else if (dbgSelectJtag) begin
            n.mode = DBG_JTAG;
        end

        // port b pin1: timer output checked first since remap overrides serial
        if (remap1 && timer2Ch1OutEn && b1Alt) begin
            n.pinOut[PIN_B1]     = timer2Ch1Out;
            n.pinDrive_b[PIN_B1] = 1'b0;
        end else if (b1SerialOwn) begin
            unique case (serial1ModeSelect)
                SER_SPI: begin
                    if (b1Alt) begin
                        n.pinOut[PIN_B1]     = serial1SpiMaster ? spiMasterOut
                                                                : spiSlaveOut;
                        n.pinDrive_b[PIN_B1] = 1'b0;
                    end
                end
                SER_TWI: begin
                    if (b1Od) begin
                        n.pinOut[PIN_B1]     = 1'b0;
                        n.pinDrive_b[PIN_B1] = twiDataOut;
                    end
                end
                SER_UART: begin
                    if (b1Alt) begin
                        n.pinOut[PIN_B1]     = uartTx;
                        n.pinDrive_b[PIN_B1] = 1'b0;
                    end
                end
                SER_OFF: begin
                end
            endcase
        end

        // port b pin2
        if (remap2 && timer2Ch2OutEn && b2Alt) begin
            n.pinOut[PIN_B2]     = timer2Ch2Out;
            n.pinDrive_b[PIN_B2] = 1'b0;
        end else if (serial1ModeSelect == SER_TWI && b2SerialOwn && b2Od) begin
            n.pinOut[PIN_B2]     = 1'b0;
            n.pinDrive_b[PIN_B2] = twiClockOut;
        end

        // inputs toward serial controller and timer
        n.spiMasterIn = (serial1ModeSelect == SER_SPI && serial1SpiMaster)
                        ? sy[PIN_B2] : 1'b0;
        n.spiSlaveIn  = (serial1ModeSelect == SER_SPI && !serial1SpiMaster)
                        ? sy[PIN_B2] : 1'b0;
        n.uartRx      = (serial1ModeSelect == SER_UART) ? sy[PIN_B2] : 1'b1;
        n.twiDataIn   = (serial1ModeSelect == SER_TWI) ? sy[PIN_B1] : 1'b1;
        n.twiClockIn  = (serial1ModeSelect == SER_TWI) ? sy[PIN_B2] : 1'b1;
        n.t2c1Cap     = remap1 ? sy[SY_T2C1_ALT] : sy[PIN_B1];
        n.t2c2Cap     = remap2 ? sy[PIN_B2] : sy[SY_T2C2_ALT];

        // debug clock pin
        if (swd) begin
            n.dbgClkOut      = swClockOut;
            n.dbgClkDrive_b  = !swClockDriveEn;
            n.dbgClkPullDown = 1'b0;
        end else begin
            n.dbgClkOut      = 1'b0;
            n.dbgClkDrive_b  = 1'b1;
            n.dbgClkPullDown = 1'b1;
        end
        n.swClockIn   = swd ? sy[SY_DBG_CLK] : 1'b0;
        n.jtagClockIn = swd ? 1'b0 : sy[SY_DBG_CLK];

        // port c pin2
        if (c2Gpio) begin
        end else if (c2Trace) begin
            n.pinOut[PIN_C2]     = asyncTraceOut;
            n.pinDrive_b[PIN_C2] = 1'b0;
            n.pinPullUp[PIN_C2]  = 1'b1;
        end else if (!swd && !dbgDisable) begin
            n.pinOut[PIN_C2]     = jtagTdo;
            n.pinDrive_b[PIN_C2] = 1'b0;
        end

        // port c pin3: trace clock is offered only once jtag has let go of it
        n.jtagTdiIn = 1'b1;
        if (c3Gpio && c3Trace) begin
            n.pinOut[PIN_C3]     = syncTraceClock;
            n.pinDrive_b[PIN_C3] = 1'b0;
        end else if (!c3Gpio) begin
            n.pinDrive_b[PIN_C3] = 1'b1;
            n.pinPullUp[PIN_C3]  = 1'b1;
            n.jtagTdiIn          = sy[PIN_C3];
        end

        // port c pin4
        n.jtagTmsIn = 1'b1;
        n.swdioIn   = 1'b1;
        if (!dbgDisable) begin
            n.pinPullUp[PIN_C4] = 1'b1;
            if (swd) begin
                n.pinOut[PIN_C4]     = swdioOut;
                n.pinDrive_b[PIN_C4] = !swdioDriveEn;
                n.swdioIn            = sy[PIN_C4];
            end else begin
                n.pinDrive_b[PIN_C4] = 1'b1;
                n.jtagTmsIn          = sy[PIN_C4];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= MUX_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign muxPinOut          = s.pinOut;
    assign muxPinDrive_b      = s.pinDrive_b;
    assign muxPinPullUp       = s.pinPullUp;
    assign dbgClkPinOut       = s.dbgClkOut;
    assign dbgClkPinDrive_b   = s.dbgClkDrive_b;
    assign dbgClkPinPullDown  = s.dbgClkPullDown;
    assign gpioIn             = s.gpioIn;
    assign spiMasterIn        = s.spiMasterIn;
    assign spiSlaveIn         = s.spiSlaveIn;
    assign uartRx             = s.uartRx;
    assign twiDataIn          = s.twiDataIn;
    assign twiClockIn         = s.twiClockIn;
    assign timer2Ch1CaptureIn = s.t2c1Cap;
    assign timer2Ch2CaptureIn = s.t2c2Cap;
    assign jtagClockIn        = s.jtagClockIn;
    assign swClockIn          = s.swClockIn;
    assign jtagTdiIn          = s.jtagTdiIn;
    assign jtagTmsIn          = s.jtagTmsIn;
    assign swdioIn            = s.swdioIn;
    assign serialWireMode     = s.mode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence sSpiSlave;
        serial1ModeSelect == SER_SPI && !serial1SpiMaster && b1Alt && !remap1;
    endsequence
    sequence sExtReset;
        !sy[SY_EXT_RST];
    endsequence
    sequence sSwitchReq;
        dbgSelectSw && sy[SY_EXT_RST];
    endsequence

    a_spi_slave_out:
    assert property (sSpiSlave |=> muxPinOut[PIN_B1] == $past(spiSlaveOut)
                     && !muxPinDrive_b[PIN_B1]) else $error("slave data not on pin1");
    a_spi_master_out:
    assert property (serial1ModeSelect == SER_SPI && serial1SpiMaster && b1Alt && !remap1
                     |=> muxPinOut[PIN_B1] == $past(spiMasterOut))
        else $error("master data not on pin1");
    a_twi_open_drain:
    assert property (serial1ModeSelect == SER_TWI && b1Od && b1SerialOwn
                     |=> !muxPinOut[PIN_B1] && muxPinDrive_b[PIN_B1] == $past(twiDataOut))
        else $error("twi data not open drain");
    a_uart_tx_out:
    assert property (serial1ModeSelect == SER_UART && b1Alt && !remap1
                     |=> muxPinOut[PIN_B1] == $past(uartTx)) else $error("uart tx lost");
    a_timer_owns_pin1:
    assert property (remap1 && timer2Ch1OutEn && b1Alt
                     |=> muxPinOut[PIN_B1] == $past(timer2Ch1Out) && !muxPinDrive_b[PIN_B1])
        else $error("timer1 output not on pin1");
    a_capture_pin1:
    assert property (!remap1 |=> timer2Ch1CaptureIn == $past(sy[PIN_B1]))
        else $error("capture not from pin1");
    a_uart_rx_in:
    assert property (serial1ModeSelect == SER_UART |=> uartRx == $past(sy[PIN_B2]))
        else $error("uart rx not from pin2");
    a_jtag_on_reset:
    assert property (sExtReset |=> !serialWireMode ##1 (!serialWireMode || $past(dbgSelectSw)))
        else $error("external reset left serial-wire mode");
    a_switch_to_sw:
    assert property (sSwitchReq |=> serialWireMode ##1 (serialWireMode || !$past(sy[SY_EXT_RST])
                     || $past(dbgSelectJtag))) else $error("serial-wire switch lost");
    a_jtag_clk_pull:
    assert property (!serialWireMode |=> dbgClkPinPullDown && dbgClkPinDrive_b)
        else $error("jtag clock pin not pulled down");
    a_tdo_drive:
    assert property (!serialWireMode && !dbgDisable
                     |=> !muxPinDrive_b[PIN_C2] && muxPinOut[PIN_C2] == $past(jtagTdo))
        else $error("tdo not driven");
    a_pin4_gpio:
    assert property (dbgDisable |=> !muxPinPullUp[PIN_C4]
                     && muxPinDrive_b[PIN_C4] == !$past(gpioDriveEn[PIN_C4]))
        else $error("pin4 not released to gpio");

endmodule : serial_timer_debug_pin_mux

// ### src/pin_mux_pkg.sv
// constants, types and the reset state of the port b / debug pin multiplexer
// assumes one system clock; config inputs come from registers on that clock

package pin_mux_pkg;

    // ------------------------------------------------------------
    // pin and synchroniser indices
    // ------------------------------------------------------------
    localparam int NUM_PINS    = 5;
    localparam int PIN_B1      = 0;
    localparam int PIN_B2      = 1;
    localparam int PIN_C2      = 2;
    localparam int PIN_C3      = 3;
    localparam int PIN_C4      = 4;
    localparam int SYNC_W      = 9;
    localparam int SY_DBG_CLK  = 5;
    localparam int SY_EXT_RST  = 6;
    localparam int SY_T2C1_ALT = 7;
    localparam int SY_T2C2_ALT = 8;

    // ------------------------------------------------------------
    // configuration field layout
    // ------------------------------------------------------------
    localparam int CFG_W            = 16;
    localparam int FIELD_W          = 4;
    localparam int DBG_CFG_W        = 8;
    localparam int REMAP_W          = 8;
    localparam int PB1_FIELD_LSB    = 4;
    localparam int PB2_FIELD_LSB    = 8;
    localparam int PC2_FIELD_LSB    = 8;
    localparam int PC3_FIELD_LSB    = 12;
    localparam int REMAP_CH1_BIT    = 4;
    localparam int REMAP_CH2_BIT    = 5;
    localparam int DBG_DISABLE_BIT  = 5;
    localparam int PC2_HIGH_CFG_BIT = 1;

    localparam logic [FIELD_W-1:0] CFG_ALT_OUT = 4'h9;
    localparam logic [FIELD_W-1:0] CFG_ALT_OD  = 4'hd;

    typedef enum logic [1:0] {
        SER_OFF  = 2'b00,
        SER_UART = 2'b01,
        SER_SPI  = 2'b10,
        SER_TWI  = 2'b11
    } serialMode_t;

    typedef enum logic {
        DBG_JTAG = 1'b0,
        DBG_SWD  = 1'b1
    } dbgMode_t;

    // ------------------------------------------------------------
    // whole state of the multiplexer
    // ------------------------------------------------------------
    typedef struct packed {
        dbgMode_t              mode;
        logic [NUM_PINS-1:0]   pinOut;
        logic [NUM_PINS-1:0]   pinDrive_b;
        logic [NUM_PINS-1:0]   pinPullUp;
        logic [NUM_PINS-1:0]   gpioIn;
        logic                  dbgClkOut;
        logic                  dbgClkDrive_b;
        logic                  dbgClkPullDown;
        logic                  spiMasterIn;
        logic                  spiSlaveIn;
        logic                  uartRx;
        logic                  twiDataIn;
        logic                  twiClockIn;
        logic                  t2c1Cap;
        logic                  t2c2Cap;
        logic                  jtagClockIn;
        logic                  swClockIn;
        logic                  jtagTdiIn;
        logic                  jtagTmsIn;
        logic                  swdioIn;
    } muxState_t;

    localparam logic [NUM_PINS-1:0] DRIVE_B_RST = 5'h1f;
    localparam logic [NUM_PINS-1:0] PULLUP_RST  = 5'h18;
    localparam logic [NUM_PINS-1:0] ZERO_PINS   = 5'h00;

    localparam muxState_t MUX_RST = '{
        mode: DBG_JTAG, pinOut: ZERO_PINS, pinDrive_b: DRIVE_B_RST,
        pinPullUp: PULLUP_RST, gpioIn: ZERO_PINS, dbgClkOut: 1'b0,
        dbgClkDrive_b: 1'b1, dbgClkPullDown: 1'b1, spiMasterIn: 1'b0,
        spiSlaveIn: 1'b0, uartRx: 1'b1, twiDataIn: 1'b1, twiClockIn: 1'b1,
        t2c1Cap: 1'b0, t2c2Cap: 1'b0, jtagClockIn: 1'b0, swClockIn: 1'b0,
        jtagTdiIn: 1'b1, jtagTmsIn: 1'b1, swdioIn: 1'b1
    };

    function automatic logic fieldIs(input logic [CFG_W-1:0]   cfg,
                                     input int                 lsb,
                                     input logic [FIELD_W-1:0] code);
        return cfg[lsb +: FIELD_W] == code;
    endfunction : fieldIs

endpackage : pin_mux_pkg

// ### src/pin_sync.sv
// two-stage synchroniser for pin levels entering the system clock domain
// assumes inputs are slow levels; an event shorter than a clock period may be missed
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } syncState_t;

    syncState_t s;
    syncState_t n;

    if (W < 1) begin : g_check
        $error("pin_sync needs W of at least one");
    end

    // stage1 is read only by stage2
    always_comb begin
        n        = s;
        n.stage1 = asyncIn;
        n.stage2 = s.stage1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign syncOut = s.stage2;

endmodule : pin_sync

// ### sim/pin_partner.sv
// far side of the five muxed pads: debugger and serial peers on the board
// assumes the far side drives only pads it is told to; the device wins a clash
`timescale 1ns/1ps
module pin_partner (
    input  wire logic [4:0] padOut,
    input  wire logic [4:0] padDrive_b,
    input  wire logic [4:0] padPullUp,
    input  wire logic [4:0] farDrive,
    input  wire logic [4:0] farVal,
    output logic      [4:0] padLevel
);
    // released pad with no pull and no far drive shows the inverse, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!padDrive_b[i]) padLevel[i] = padOut[i];
            else if (farDrive[i]) padLevel[i] = farVal[i];
            else padLevel[i] = padPullUp[i] ? 1'b1 : !padOut[i];
        end
    end
endmodule : pin_partner

// ### sim/test_serial_timer_debug_pin_mux.sv
// self-checking bench for the port b / debug pin multiplexer
// assumes pin_partner resolves the pads; the debug core is driven from here
`timescale 1ns/1ps
module test_serial_timer_debug_pin_mux;
    import pin_mux_pkg::*;
    // ------------------------------------------------------------
    // signals and rows
    // ------------------------------------------------------------
    logic clk = 0, rst_b = 0, serial1SpiMaster, timer2Ch1OutEn, timer2Ch2OutEn, uartTx;
    serialMode_t serial1ModeSelect;
    logic [REMAP_W-1:0] timer2Remap;
    logic [DBG_CFG_W-1:0] debugPinConfig;
    logic [CFG_W-1:0] portBLowConfig, portCLowConfig, portCHighConfig;
    logic spiSlaveOut, spiMasterOut, twiDataOut, twiClockOut, timer2Ch1Out, timer2Ch2Out;
    logic dbgSelectSw, dbgSelectJtag, jtagTdo, swClockOut, swClockDriveEn, swdioOut;
    logic swdioDriveEn, asyncTraceEn, asyncTraceOut, syncTraceEn, syncTraceClock, dbgClkPinIn;
    logic externalReset_n, timer2Ch1OtherPinIn, timer2Ch2OtherPinIn, dbgClkPinOut, uartRx;
    logic dbgClkPinDrive_b, dbgClkPinPullDown, spiMasterIn, spiSlaveIn, twiDataIn, twiClockIn;
    logic timer2Ch1CaptureIn, timer2Ch2CaptureIn, jtagClockIn, swClockIn, jtagTdiIn, jtagTmsIn;
    logic swdioIn, serialWireMode;
    logic [4:0] gpioOut, gpioDriveEn, muxPinIn, muxPinOut, muxPinDrive_b, muxPinPullUp, gpioIn;
    logic [4:0] farDrive, farVal;
    int miscompares = 0, comparisons = 0;
    typedef struct packed {
        serialMode_t mode; logic master, en1; logic [7:0] remap; logic [3:0] fld; logic [1:0] exp;
    } row_t;
    // expected pair is pin1 level then pin1 drive_b
    localparam row_t ROWS [8] = '{'{SER_SPI, 1'b0, 1'b0, 8'h00, 4'h9, 2'b10},
        '{SER_SPI, 1'b1, 1'b0, 8'h00, 4'h9, 2'b00}, '{SER_UART, 1'b0, 1'b0, 8'h00, 4'h9, 2'b10},
        '{SER_TWI, 1'b0, 1'b0, 8'h00, 4'hd, 2'b00}, '{SER_SPI, 1'b0, 1'b1, 8'h10, 4'h9, 2'b00},
        '{SER_SPI, 1'b0, 1'b0, 8'h10, 4'h9, 2'b10}, '{SER_SPI, 1'b0, 1'b1, 8'h00, 4'h9, 2'b10},
        '{SER_OFF, 1'b0, 1'b0, 8'h00, 4'h0, 2'b00}};
    serial_timer_debug_pin_mux serial_timer_debug_pin_mux_inst (.clk, .rst_b,
        .serial1ModeSelect, .serial1SpiMaster, .timer2Ch1OutEn, .timer2Ch2OutEn, .timer2Remap,
        .portBLowConfig, .portCLowConfig, .portCHighConfig, .debugPinConfig, .spiSlaveOut,
        .spiMasterOut, .twiDataOut, .twiClockOut, .uartTx, .timer2Ch1Out, .timer2Ch2Out,
        .gpioOut, .gpioDriveEn, .dbgSelectSw, .dbgSelectJtag, .jtagTdo, .swClockOut,
        .swClockDriveEn, .swdioOut, .swdioDriveEn, .asyncTraceEn, .asyncTraceOut,
        .syncTraceEn, .syncTraceClock, .muxPinIn, .dbgClkPinIn, .externalReset_n,
        .timer2Ch1OtherPinIn, .timer2Ch2OtherPinIn, .muxPinOut, .muxPinDrive_b,
        .muxPinPullUp, .dbgClkPinOut, .dbgClkPinDrive_b, .dbgClkPinPullDown, .gpioIn,
        .spiMasterIn, .spiSlaveIn, .uartRx, .twiDataIn, .twiClockIn, .timer2Ch1CaptureIn,
        .timer2Ch2CaptureIn, .jtagClockIn, .swClockIn, .jtagTdiIn, .jtagTmsIn, .swdioIn,
        .serialWireMode);
    pin_partner pin_partner_inst (.padOut(muxPinOut), .padDrive_b(muxPinDrive_b),
        .padPullUp(muxPinPullUp), .farDrive(farDrive), .farVal(farVal), .padLevel(muxPinIn));
    always #50 clk = ~clk;
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic wait4;
        repeat (4) @(negedge clk);
    endtask : wait4
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {serial1SpiMaster, timer2Ch1OutEn, timer2Ch2OutEn, timer2Remap, portCLowConfig} = '0;
        {portCHighConfig, debugPinConfig, spiMasterOut, twiDataOut, timer2Ch1Out} = '0;
        {timer2Ch2Out, dbgSelectSw, dbgSelectJtag, swClockOut, swClockDriveEn, swdioOut} = '0;
        {swdioDriveEn, asyncTraceEn, asyncTraceOut, syncTraceEn, syncTraceClock} = '0;
        {timer2Ch1OtherPinIn, timer2Ch2OtherPinIn, farVal, portBLowConfig} = '0;
        {spiSlaveOut, twiClockOut, uartTx, jtagTdo, externalReset_n, dbgClkPinIn} = '1;
        serial1ModeSelect = SER_OFF;
        {gpioOut, gpioDriveEn, farDrive} = {5'h1e, 5'h1d, 5'h12};
        repeat (8) @(negedge clk);
        check("reset pads", {muxPinDrive_b, muxPinPullUp}, 10'h3f8);
        rst_b = 1;
        wait4();
        check("jtag pins", {muxPinDrive_b[2], muxPinOut[2], muxPinPullUp[4:3], dbgClkPinPullDown,
            serialWireMode, jtagTmsIn, jtagTdiIn, jtagClockIn}, 10'h0f3);
        check("gpio in", gpioIn, 10'h00c);
        foreach (ROWS[i]) begin
            serial1ModeSelect = ROWS[i].mode;
            serial1SpiMaster = ROWS[i].master;
            timer2Ch1OutEn = ROWS[i].en1;
            timer2Remap = ROWS[i].remap;
            portBLowConfig = {8'h00, ROWS[i].fld, 4'h0};
            // uart rows see a low pin so the receive path differs from its idle level
            farVal[1] = ROWS[i].mode != SER_UART;
            wait4();
            check("pin1", {muxPinOut[0], muxPinDrive_b[0]}, ROWS[i].exp);
            if (ROWS[i].mode == SER_SPI) check("spi in", {spiSlaveIn, spiMasterIn},
                {!ROWS[i].master, ROWS[i].master});
            if (ROWS[i].mode == SER_UART) check("uart rx", uartRx, farVal[1]);
            $display("row %0d done", i);
        end
        serial1ModeSelect = SER_TWI;
        {portBLowConfig, twiClockOut} = {16'h0d00, 1'b0};
        wait4();
        check("twi pins", {muxPinOut[1], muxPinDrive_b[1], twiClockIn, twiDataIn},
            10'h000);
        {timer2Remap, timer2Ch2OutEn, timer2Ch2Out} = {8'h20, 2'b11};
        {timer2Ch2OtherPinIn, timer2Ch1OtherPinIn, portBLowConfig} = {2'b01, 16'h0900};
        wait4();
        check("timer pins", {muxPinOut[1], muxPinDrive_b[1], timer2Ch2CaptureIn,
            timer2Ch1CaptureIn}, 10'h00a);
        dbgSelectSw = 1;
        @(negedge clk);
        dbgSelectSw = 0;
        wait4();
        check("serial wire", {serialWireMode, dbgClkPinPullDown, muxPinDrive_b[3],
            muxPinOut[3], muxPinPullUp[4], swdioIn}, 10'h026);
        {asyncTraceEn, syncTraceEn, swClockOut, swClockDriveEn} = 4'hf;
        portCLowConfig = 16'h9900;
        wait4();
        check("trace", {muxPinOut[3:2], muxPinDrive_b[3:2], muxPinPullUp[2]}, 10'h001);
        check("swclk", {dbgClkPinOut, dbgClkPinDrive_b, swClockIn, jtagClockIn}, 10'h00a);
        dbgSelectJtag = 1;
        @(negedge clk);
        dbgSelectJtag = 0;
        wait4();
        check("back to jtag", serialWireMode, 1'b0);
        dbgSelectSw = 1;
        @(negedge clk);
        dbgSelectSw = 0;
        wait4();
        externalReset_n = 0;
        wait4();
        check("ext reset", {serialWireMode, dbgClkPinPullDown}, 10'h001);
        {externalReset_n, jtagTdo, debugPinConfig} = {2'b10, 8'h20};
        wait4();
        check("debug off", {muxPinOut[4], muxPinDrive_b[4], muxPinOut[2]}, 10'h005);
        $display("hand tests done");
        end_of_test();
    end
    initial begin
        #200us;
        miscompares++;
        end_of_test();
    end
endmodule : test_serial_timer_debug_pin_mux
